// File: logic/fps_supervisor.sv
// watchdog, oscillator supervisor and power mode control
`timescale 1ns/1ps
// Functional notes
// - 15-bit watchdog counter steps at oscillator/12 or oscillator/384.
// - only the upper 7 counter bits are loadable, setting overflow period.
// - watchdog starts from software start bit or hardware start pin.
// - once started the watchdog cannot be stopped in active operation.
// - overflow without refresh triggers an internal reset.
// - valid refresh loads the reload value into the upper 7 bits.
// - readable flag tells whether last reset came from the watchdog.
// - counter is frozen in idle and power-down.
// - timeout spans 192 us to about 0.79 s at 16 MHz.
// - slow oscillator switches clock to rc and holds reset.
// - after oscillator recovers reset stays about 0.5 ms longer.
// - hardware power-down exit reuses the oscillator recovery sequence.
// - at power-on reset logic runs from rc until oscillator starts.
// - idle gates cpu clock; peripherals keep clock.
// - idle ends on peripheral interrupt or hardware reset, state kept.
// - power-down stops oscillator and all operation, keeps ram and registers.
// - software power-down: 02H then 40H; left only by hardware reset.
// - low power-down pin enters power-down, high level ends it.
// - slow-down bit 10H divides clocks by eight; clear or reset restores.
// - hardware reset from a power mode discards state, normal reset.
module fps_supervisor
  import fps_pkg::*;
#(
  parameter int HOLD_CYC = OSC_HOLD_CYC
) (
  input wire logic ref_clk, // oscillator-derived system clock
  input wire logic rst_b, // external hardware reset, active low
  input wire logic rc_clk_tick, // auxiliary rc oscillator, raw level
  input wire logic hw_watchdog_start_pin, // watchdog start pin, high starts
  input wire logic hw_powerdown_pin_b, // power-down pin, active low
  input wire logic periph_irq, // interrupt request from peripherals
  input wire logic [3:0] reg_addr, // register index
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [7:0] reg_rdata, // read data, cycle after strobe
  output logic int_reset, // internal reset to the core
  output logic cpu_clk_en, // cpu clock enable
  output logic periph_clk_en, // peripheral clock enable
  output logic osc_enable, // oscillator run enable
  output logic rc_clock_sel // core clock taken from rc oscillator
);

  localparam int HW = $clog2(HOLD_CYC + 1);

  typedef enum logic [1:0] {OS_RUN, OS_FAIL, OS_HOLD} fps_osc_type;

  logic rst_s1_q;
  logic rst_s2_q;
  logic rc1_q;
  logic rc2_q;
  logic rc3_q;
  logic wds1_q;
  logic wds2_q;
  logic pd1_q;
  logic pd2_q;
  logic [7:0] power_control_register_q;
  logic [7:0] wdrel_q;
  logic [WD_BITS-1:0] wd_cnt_q;
  logic wd_run_q;
  logic wd_cause_q;
  logic wd_ovf_q;
  logic refresh_arm_q;
  logic idle_arm_q;
  logic pd_arm_q;
  logic idle_q;
  logic swpd_q;
  logic [8:0] pre_q;
  logic [2:0] slow_q;
  logic [3:0] rc_win_q;
  logic [7:0] osc_cnt_q;
  logic [HW-1:0] hold_q;
  fps_osc_type osc_q;
  logic osc_slow_q;
  logic rst_n;
  logic wr_power_control_register;
  logic wr_wdctl;
  logic wr_wdrel;
  logic refresh_go;
  logic start_req;
  logic wd_wrap;
  logic wd_gate;
  logic wd_tick;
  logic slow_tick;
  logic rc_edge;
  logic hw_powerdown_pin;
  logic core_ok;

  // release of the external reset is synchronised; assertion stays asynchronous
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;

  // rc level is sampled as data; only rc3_q follows the second flop
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rc1_q <= 1'b0;
      rc2_q <= 1'b0;
      rc3_q <= 1'b0;
    end else begin
      rc1_q <= rc_clk_tick;
      rc2_q <= rc1_q;
      rc3_q <= rc2_q;
    end
  end

  // watchdog start pin, two flops
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wds1_q <= 1'b0;
      wds2_q <= 1'b0;
    end else begin
      wds1_q <= hw_watchdog_start_pin;
      wds2_q <= wds1_q;
    end
  end

  // reset to the pin's idle high level so no false entry follows reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pd1_q <= 1'b1;
      pd2_q <= 1'b1;
    end else begin
      pd1_q <= hw_powerdown_pin_b;
      pd2_q <= pd1_q;
    end
  end
  assign rc_edge = rc2_q & ~rc3_q;
  assign hw_powerdown_pin = ~pd2_q;

  assign wr_power_control_register = reg_wr && reg_addr == ADDR_POWER_CONTROL_REGISTER;
  assign wr_wdctl = reg_wr && reg_addr == ADDR_WDCTL;
  assign wr_wdrel = reg_wr && reg_addr == ADDR_WDREL;
  // a watchdog wrap shows as a one-cycle core reset
  assign core_ok = osc_q == OS_RUN && !wd_ovf_q;

  // slow-down is the only stored power bit; writing it low restores full clock
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      power_control_register_q <= POWER_CONTROL_REGISTER_RST;
    end else if (wr_power_control_register) begin
      power_control_register_q[PC_SLOW] <= reg_wdata[PC_SLOW];
    end
  end

  // first steps arm for one cycle only; any other cycle disarms
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_arm_q <= 1'b0;
      pd_arm_q <= 1'b0;
    end else begin
      idle_arm_q <= wr_power_control_register && reg_wdata[PC_IDLE1];
      pd_arm_q <= wr_power_control_register && reg_wdata[PC_PD1];
    end
  end

  // idle entry wins over a wake request in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_q <= 1'b0;
    end else if (wr_power_control_register && idle_arm_q && reg_wdata[PC_IDLE2]) begin
      idle_q <= 1'b1;
    end else if (periph_irq) begin
      idle_q <= 1'b0;
    end
  end

  // software power-down is left only through the external reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      swpd_q <= 1'b0;
    end else if (wr_power_control_register && pd_arm_q && reg_wdata[PC_PD2]) begin
      swpd_q <= 1'b1;
    end
  end

  // slow-down enable: one pulse in eight
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      slow_q <= 3'd0;
    end else begin
      slow_q <= (slow_q == SLOW_DIV) ? 3'd0 : slow_q + 3'd1;
    end
  end
  assign slow_tick = !power_control_register_q[PC_SLOW] || slow_q == SLOW_DIV;

  // prescaler /12 or /384, held in idle and power-down
  assign wd_gate = slow_tick && !idle_q && !swpd_q && !hw_powerdown_pin;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= 9'd0;
    end else if (wd_gate) begin
      pre_q <= wd_tick ? 9'd0 : pre_q + 9'd1;
    end
  end
  assign wd_tick = wd_gate &&
    pre_q == ((wdrel_q[WR_PRESC] ? DIV_SLOW : DIV_FAST) - 9'd1);

  // reload register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wdrel_q <= WDREL_RST;
    end else if (wr_wdrel) begin
      wdrel_q <= reg_wdata;
    end
  end

  // a reload has priority over the step, so a refresh never wraps
  assign refresh_go = wr_wdctl && reg_wdata[WC_START] && refresh_arm_q;
  assign start_req = (wr_wdctl && reg_wdata[WC_START]) || wds2_q;
  assign wd_wrap = wd_run_q && wd_tick && !refresh_go && wd_cnt_q == 15'h7fff;

  // refresh step one is good for the very next cycle only
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      refresh_arm_q <= 1'b0;
    end else begin
      refresh_arm_q <= wr_wdctl && reg_wdata[WC_REFRESH];
    end
  end

  // no software path clears the run flag; only a wrap or the external reset ends the cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wd_run_q <= 1'b0;
    end else if (wd_wrap) begin
      wd_run_q <= 1'b0;
    end else if (start_req) begin
      wd_run_q <= 1'b1;
    end
  end

  // overflow pulse
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wd_ovf_q <= 1'b0;
    end else begin
      wd_ovf_q <= wd_wrap;
    end
  end

  // watchdog counter
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wd_cnt_q <= WD_RST;
    end else if (refresh_go) begin
      wd_cnt_q <= {wdrel_q[6:0], 8'h00};
    end else if (wd_run_q && wd_tick) begin
      wd_cnt_q <= wd_cnt_q + 15'h0001;
    end
  end

  // reset cause flag survives the watchdog reset, cleared by external reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wd_cause_q <= 1'b0;
    end else if (wd_ovf_q) begin
      wd_cause_q <= 1'b1;
    end
  end

  // oscillator supervisor: count ref edges per rc window
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rc_win_q <= 4'd0;
      osc_cnt_q <= 8'd0;
      osc_slow_q <= 1'b0;
    end else if (rc_edge) begin
      rc_win_q <= rc_win_q + 4'd1;
      // verdict only once per window, so rc jitter cannot chatter the reset
      if (rc_win_q == RC_WIN - 4'd1) begin
        osc_slow_q <= osc_cnt_q < OSC_MIN;
        osc_cnt_q <= 8'd0;
        rc_win_q <= 4'd0;
      end
    end else if (osc_cnt_q != 8'hff) begin
      osc_cnt_q <= osc_cnt_q + 8'd1;
    end
  end

  // failure, power-on and power-down exit share one hold sequence
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_q <= OS_HOLD;
    end else begin
      case (osc_q)
        OS_RUN: begin
          if (osc_slow_q || hw_powerdown_pin) begin
            osc_q <= OS_FAIL;
          end
        end
        OS_FAIL: begin
          if (!osc_slow_q && !hw_powerdown_pin) begin
            osc_q <= OS_HOLD;
          end
        end
        default: begin
          if (osc_slow_q || hw_powerdown_pin) begin
            osc_q <= OS_FAIL;
          end else if (hold_q == HW'(HOLD_CYC - 1)) begin
            osc_q <= OS_RUN;
          end
        end
      endcase
    end
  end

  // hold count restarts outside the hold state so every recovery waits in full
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_q <= '0;
    end else if (osc_q != OS_HOLD) begin
      hold_q <= '0;
    end else if (hold_q != HW'(HOLD_CYC - 1)) begin
      hold_q <= hold_q + HW'(1);
    end
  end

  // read port
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == ADDR_POWER_CONTROL_REGISTER) begin
        reg_rdata <= power_control_register_q;
      end else if (reg_addr == ADDR_WDCTL) begin
        reg_rdata <= 8'h00; // control bits are write-only
      end else if (reg_addr == ADDR_WDREL) begin
        reg_rdata <= wdrel_q;
      end else if (reg_addr == ADDR_STATUS) begin
        reg_rdata <= {4'h0, idle_q, swpd_q, wd_run_q, wd_cause_q};
      end else if (reg_addr == ADDR_WDCNT) begin
        reg_rdata <= wd_cnt_q[14:7];
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  assign int_reset = !core_ok;
  assign rc_clock_sel = osc_q != OS_RUN;
  assign osc_enable = !swpd_q && !hw_powerdown_pin;
  assign periph_clk_en = slow_tick && osc_enable;
  assign cpu_clk_en = periph_clk_en && !idle_q;

endmodule

// File: logic/fps_pkg.sv
// constants for the failsafe power supervisor
package fps_pkg;
  localparam int CLK_MHZ = 200;
  // register indices on the plain port
  localparam logic [3:0] ADDR_POWER_CONTROL_REGISTER = 4'h0;
  localparam logic [3:0] ADDR_WDCTL = 4'h1;
  localparam logic [3:0] ADDR_WDREL = 4'h2;
  localparam logic [3:0] ADDR_STATUS = 4'h3;
  localparam logic [3:0] ADDR_WDCNT = 4'h4;
  // power control bit positions
  localparam int PC_IDLE1 = 0;
  localparam int PC_PD1 = 1;
  localparam int PC_SLOW = 4;
  localparam int PC_IDLE2 = 5;
  localparam int PC_PD2 = 6;
  // watchdog control bit positions
  localparam int WC_REFRESH = 0;
  localparam int WC_START = 1;
  // reload field: bit 7 selects the /384 rate
  localparam int WR_PRESC = 7;
  localparam logic [7:0] WDREL_RST = 8'h00;
  localparam logic [7:0] POWER_CONTROL_REGISTER_RST = 8'h00;
  // dividers in oscillator cycles
  localparam logic [8:0] DIV_FAST = 9'd12;
  localparam logic [8:0] DIV_SLOW = 9'd384;
  localparam logic [2:0] SLOW_DIV = 3'd7;
  localparam int WD_BITS = 15;
  localparam logic [WD_BITS-1:0] WD_RST = 15'h0000;
  // final oscillator reset phase
  localparam int OSC_HOLD_US = 500;
  localparam int OSC_HOLD_CYC = OSC_HOLD_US * CLK_MHZ;
  // rc vs oscillator comparison window in rc edges
  localparam logic [3:0] RC_WIN = 4'd8;
  localparam logic [7:0] OSC_MIN = 8'd8;
endpackage

// File: verif/fps_cpu_model.sv
// cpu-side partner: register bus master and free-running rc oscillator
`timescale 1ns/1ps
module fps_cpu_model #(
  parameter int RC_HALF_NS = 15
) (
  input logic ref_clk, // system clock
  output logic [3:0] reg_addr, // register index
  output logic [7:0] reg_wdata, // write data
  output logic reg_wr, // write strobe
  output logic reg_rd, // read strobe
  output logic rc_clk_tick // rc oscillator
);
  initial begin
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    rc_clk_tick = 1'b0;
    forever #(RC_HALF_NS) rc_clk_tick = ~rc_clk_tick;
  end
  // back-to-back calls keep strobes high, two-step sequences need that
  task automatic put(input logic w, r, input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
  endtask
endmodule

// File: verif/fps_supervisor_assertions.sv
// port assertions for the supervisor
`timescale 1ns/1ps
module fps_sup_chk
  import fps_pkg::*;
#(
  parameter int HOLD_CYC = 20
) (
  input logic ref_clk, // clock
  input logic rst_b, // reset
  input logic rc_clk_tick, // rc
  input logic hw_watchdog_start_pin, // wd pin
  input logic hw_powerdown_pin_b, // pd pin
  input logic periph_irq, // irq
  input logic [3:0] reg_addr, // addr
  input logic [7:0] reg_wdata, // wdata
  input logic reg_wr, // write
  input logic reg_rd, // read
  input logic [7:0] reg_rdata, // rdata
  input logic int_reset, // core reset
  input logic cpu_clk_en, // cpu enable
  input logic periph_clk_en, // periph enable
  input logic osc_enable, // osc run
  input logic rc_clock_sel // rc select
);
  int hi_cnt;
  always_ff @(posedge ref_clk) hi_cnt <= int_reset ? hi_cnt + 1 : 0;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_pd_stops_clocks: assert property (!osc_enable |-> !cpu_clk_en && !periph_clk_en)
    else $error("clock enabled while oscillator off");
  a_cpu_needs_periph: assert property (cpu_clk_en |-> periph_clk_en)
    else $error("cpu clocked while peripherals stopped");
  a_unmapped_zero: assert property (reg_rd && reg_addr > ADDR_WDCNT |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without read");
  a_hw_powerdown_pin_osc_off: assert property (!hw_powerdown_pin_b [*5] |-> !osc_enable)
    else $error("oscillator runs in hardware power-down");
  a_rc_sel_reset: assert property (rc_clock_sel && osc_enable |-> int_reset)
    else $error("rc clock selected without reset");
  a_hold_length: assert property ($fell(int_reset) |-> hi_cnt == 1 || hi_cnt >= HOLD_CYC)
    else $error("reset hold too short");
  a_idle_entry: assert property (reg_wr && reg_addr == ADDR_POWER_CONTROL_REGISTER && reg_wdata[PC_IDLE1] ##1
    reg_wr && reg_addr == ADDR_POWER_CONTROL_REGISTER && reg_wdata[PC_IDLE2] && !periph_irq |=> !cpu_clk_en)
    else $error("idle not entered");
  a_swpd_entry: assert property (reg_wr && reg_addr == ADDR_POWER_CONTROL_REGISTER && reg_wdata[PC_PD1] ##1
    reg_wr && reg_addr == ADDR_POWER_CONTROL_REGISTER && reg_wdata[PC_PD2] |=> !osc_enable)
    else $error("software power-down not entered");
  c_hold_end: cover property ($fell(int_reset));
  c_idle: cover property (!cpu_clk_en && periph_clk_en);
  c_pd: cover property (!osc_enable);
endmodule
bind fps_supervisor fps_sup_chk #(.HOLD_CYC(HOLD_CYC)) fps_sup_chk_inst (.ref_clk, .rst_b, .rc_clk_tick,
  .hw_watchdog_start_pin, .hw_powerdown_pin_b, .periph_irq, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .int_reset, .cpu_clk_en, .periph_clk_en, .osc_enable, .rc_clock_sel);

// File: verif/tb_top.sv
// self-checking bench for the supervisor
`timescale 1ns/1ps
module tb_top;
  import fps_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic hw_powerdown_pin_b = 1'b1;
  logic periph_irq = 1'b0;
  logic hw_watchdog_start_pin = 1'b0;
  logic rc_clk_tick, reg_wr, reg_rd, int_reset, cpu_clk_en, periph_clk_en, osc_enable, rc_clock_sel;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rel;
  logic [7:0] exp_q[$], msk_q[$];
  logic rd_seen = 1'b0;
  int miscompares = 0, comparisons = 0, seed = 26441, n, e;
  initial forever #2.5 ref_clk = ~ref_clk;
  fps_cpu_model fps_cpu_model_inst (.ref_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .rc_clk_tick);
  fps_supervisor #(.HOLD_CYC(20)) fps_supervisor_inst (.ref_clk, .rst_b, .rc_clk_tick,
    .hw_watchdog_start_pin, .hw_powerdown_pin_b, .periph_irq, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .int_reset, .cpu_clk_en, .periph_clk_en, .osc_enable, .rc_clock_sel);
  task automatic check(input logic [7:0] got, exp, msk);
    comparisons++;
    if ((got & msk) !== (exp & msk)) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bit_is(input logic got, exp);
    check({7'h00, got}, {7'h00, exp}, 8'h01);
  endtask
  task automatic give_verdict;
    if (miscompares == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    fps_cpu_model_inst.put(1'b1, 1'b0, a, d);
  endtask
  // released bus lines show the inverse so stale values cannot pass
  task automatic idle;
    fps_cpu_model_inst.put(1'b0, 1'b0, ~reg_addr, ~reg_wdata);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] ex, m);
    exp_q.push_back(ex);
    msk_q.push_back(m);
    fps_cpu_model_inst.put(1'b0, 1'b1, a, reg_wdata);
    idle;
  endtask
  task automatic wait_low(input int lim);
    n = 0;
    while (int_reset !== 1'b0 && n < lim) begin
      @(negedge ref_clk);
      n++;
    end
    bit_is(n < lim, 1'b1);
  endtask
  task automatic count_en(input logic [7:0] ex);
    n = 0;
    repeat (64) begin
      @(negedge ref_clk);
      n += cpu_clk_en;
    end
    check(8'(n), ex, 8'hFF);
  endtask
  always @(posedge ref_clk) rd_seen <= reg_rd;
  always @(negedge ref_clk) if (rd_seen) check(reg_rdata, exp_q.pop_front(), msk_q.pop_front());
  initial begin
    #150_000;
    miscompares++;
    give_verdict;
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    wait_low(200);
    bit_is(rc_clock_sel, 1'b0);
    rd(ADDR_STATUS, 8'h00, 8'h0F);
    rd(4'(5 + $unsigned($random(seed)) % 11), 8'h00, 8'hFF);
    wr(ADDR_POWER_CONTROL_REGISTER, 8'h01);
    wr(ADDR_POWER_CONTROL_REGISTER, 8'h20);
    idle;
    @(negedge ref_clk);
    bit_is(cpu_clk_en, 1'b0);
    bit_is(periph_clk_en, 1'b1);
    @(posedge ref_clk) periph_irq <= 1'b1;
    @(posedge ref_clk) periph_irq <= 1'b0;
    @(negedge ref_clk) bit_is(cpu_clk_en, 1'b1);
    wr(ADDR_POWER_CONTROL_REGISTER, 8'h01);
    idle;
    wr(ADDR_POWER_CONTROL_REGISTER, 8'h20);
    idle;
    @(negedge ref_clk) bit_is(cpu_clk_en, 1'b1);
    wr(ADDR_POWER_CONTROL_REGISTER, 8'h10);
    idle;
    count_en(8'h08);
    wr(ADDR_POWER_CONTROL_REGISTER, 8'h00);
    idle;
    count_en(8'h40);
    @(posedge ref_clk) hw_powerdown_pin_b <= 1'b0;
    repeat (8) @(negedge ref_clk);
    bit_is(osc_enable, 1'b0);
    bit_is(periph_clk_en, 1'b0);
    @(posedge ref_clk) hw_powerdown_pin_b <= 1'b1;
    repeat (4) @(posedge ref_clk);
    wait_low(400);
    bit_is(osc_enable, 1'b1);
    rel = 8'h7C | 8'($random(seed) & 3);
    wr(ADDR_WDREL, rel);
    wr(ADDR_WDCTL, 8'h01);
    wr(ADDR_WDCTL, 8'h02);
    idle;
    rd(ADDR_WDCNT, {rel[6:0], 1'b0}, 8'hFF);
    rd(ADDR_STATUS, 8'h02, 8'h02);
    e = (128 - rel[6:0]) * 3072;
    n = 0;
    while (int_reset !== 1'b1 && n < 20000) begin
      @(negedge ref_clk);
      n++;
    end
    bit_is(n > e - 40 && n < e + 40, 1'b1);
    repeat (3) @(posedge ref_clk);
    rd(ADDR_STATUS, 8'h01, 8'h01);
    wr(ADDR_POWER_CONTROL_REGISTER, 8'h02);
    wr(ADDR_POWER_CONTROL_REGISTER, 8'h40);
    idle;
    @(negedge ref_clk) bit_is(osc_enable, 1'b0);
    @(posedge ref_clk) periph_irq <= 1'b1;
    @(posedge ref_clk) periph_irq <= 1'b0;
    @(negedge ref_clk) bit_is(osc_enable, 1'b0);
    @(posedge ref_clk) rst_b <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    wait_low(200);
    bit_is(osc_enable, 1'b1);
    rd(ADDR_STATUS, 8'h00, 8'h0F);
    @(posedge ref_clk) hw_watchdog_start_pin <= 1'b1;
    repeat (4) @(posedge ref_clk);
    hw_watchdog_start_pin <= 1'b0;
    wr(ADDR_WDCTL, 8'h00);
    idle;
    rd(ADDR_STATUS, 8'h02, 8'h02);
    repeat (3) @(posedge ref_clk);
    give_verdict;
  end
endmodule
